// ---- dv/sdl_host_model.sv ----
`timescale 1ns/1ps
module sdl_host_model (
	output logic frame_sel_n_o, // Frame select
	output logic shift_clk_o, // Shift clock, still between send calls
	output logic serial_in_o, // Serial data
	input wire logic sdo_i // Serial out wire level
);
	logic [31:0] rd;
	initial begin
		frame_sel_n_o = 1'b1;
		shift_clk_o = 1'b1;
		serial_in_o = 1'b0;
		rd = '0;
	end
	// MSB first; sel 0 toggles the pins with the frame left closed
	task automatic send(input logic [31:0] w, input int n, input bit sel);
		rd = '0;
		frame_sel_n_o = !sel;
		#80;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in_o = w[i];
			#80 shift_clk_o = 1'b0;
			rd = {rd[30:0], sdo_i};
			#80 shift_clk_o = 1'b1;
		end
		#80 frame_sel_n_o = 1'b1;
		// Stale data must not look valid after the frame
		serial_in_o = !serial_in_o;
		#80;
	endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import sdl_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic ld_n = 1'b1;
	logic clr_n = 1'b1;
	logic pd_n = 1'b1;
	logic fs_n, sclk, sdi, serial_out, oe, zero, sdo_lvl;
	logic [15:0] code;
	sdl_switch_s sw;
	int failures = 0;
	int samples_checked = 0;
	assign serial_out = !oe;
	initial forever #2.5 clk_sys_i = !clk_sys_i;
	sdl_loader u_sdl_loader (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.frame_sel_n_i(fs_n), .shift_clk_i(sclk), .serial_in_i(sdi),
		.load_output_n_i(ld_n), .output_clear_n_i(clr_n), .power_down_n_i(pd_n),
		.serial_out_o(sdo_lvl), .serial_out_oe_o(oe), .output_zero_o(zero),
		.dac_code_o(code), .switch_o(sw));
	sdl_host_model u_sdl_host_model (.frame_sel_n_o(fs_n), .shift_clk_o(sclk),
		.serial_in_o(sdi), .sdo_i(serial_out));
	// ----------------------------------------
	// Checks and scenarios
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wt;
		repeat (8) @(negedge clk_sys_i);
	endtask
	task automatic ld(input logic v);
		@(negedge clk_sys_i) ld_n <= v;
		wt();
	endtask
	task automatic chk_code(input logic [15:0] c);
		chk("dac", {16'h0, c}, {16'h0, code});
		chk("seg", (32'h1 << c[15:12]) - 32'h1, {17'h0, sw.segment_switch});
		chk("ladder", {20'h0, c[11:0]}, {20'h0, sw.ladder_switch});
	endtask
	task automatic t_load;
		chk_code(16'h8000);
		ld(1'b0);
		u_sdl_host_model.send(32'h1234, 16, 1'b1);
		wt();
		chk_code(16'h1234);
		ld(1'b1);
		u_sdl_host_model.send(32'h0, 16, 1'b1);
		wt();
		chk_code(16'h1234);
		ld(1'b0);
		chk_code(16'h0000);
		ld(1'b1);
	endtask
	task automatic t_refuse;
		u_sdl_host_model.send(32'hFFFF, 8, 1'b1);
		u_sdl_host_model.send(32'hFFFF, 16, 1'b0);
		chk("idle_sdo", 32'h0, {16'h0, u_sdl_host_model.rd[15:0]});
		ld(1'b0);
		chk_code(16'h0000);
		ld(1'b1);
	endtask
	task automatic t_read;
		u_sdl_host_model.send(32'hFFFF, 16, 1'b1);
		chk("rd0", 32'h0, {16'h0, u_sdl_host_model.rd[15:0]});
		ld(1'b0);
		chk_code(16'hFFFF);
		ld(1'b1);
		u_sdl_host_model.send(32'hABCD5A5A, 32, 1'b1);
		chk("chain", 32'hFFFFABCD, u_sdl_host_model.rd);
		chk("sdo_lvl", 32'h0, {31'h0, sdo_lvl});
		ld(1'b0);
		chk_code(16'h5A5A);
		ld(1'b1);
	endtask
	task automatic t_clear;
		@(negedge clk_sys_i) clr_n <= 1'b0;
		wt();
		@(negedge clk_sys_i) clr_n <= 1'b1;
		wt();
		chk("zero", 32'h1, {31'h0, zero});
		chk_code(16'h5A5A);
		ld(1'b0);
		chk("zero", 32'h0, {31'h0, zero});
		ld(1'b1);
		@(negedge clk_sys_i) pd_n <= 1'b0;
		u_sdl_host_model.send(32'h7FFF, 16, 1'b1);
		ld(1'b0);
		chk("pd", 32'h2, {30'h0, zero, oe});
		chk_code(16'h7FFF);
		@(negedge clk_sys_i) pd_n <= 1'b1;
		ld(1'b1);
	endtask
	task automatic give_verdict;
		if (failures == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk_sys_i);
		resetn_i = 1'b1;
		wt();
		t_load();
		t_refuse();
		t_read();
		t_clear();
		give_verdict();
	end
	initial begin
		#200000;
		failures++;
		give_verdict();
	end
endmodule

// ---- hw/sdl_decoder.sv ----
`timescale 1ns/1ps
`include "sdl_defines.svh"
module sdl_decoder
	import sdl_pkg::*;
(
	input wire logic [15:0] code_i, // DAC code, straight binary
	output sdl_switch_s sw_o // Segment and ladder controls
);
	// ----------------------------------------
	// Thermometer and ladder decode
	// ----------------------------------------
	always_comb begin
		sw_o = '0;
		for (int k = 0; k < `SDL_SEG_COUNT; k++) begin
			sw_o.segment_switch[k] = (32'(code_i[15:12]) > k); // RULE11 RULE3
		end
		sw_o.ladder_switch = code_i[11:0]; // RULE12
	end
endmodule

// ---- hw/sdl_defines.svh ----
`ifndef SDL_DEFINES_SVH
`define SDL_DEFINES_SVH
`define SDL_WORD_BITS 16
`define SDL_MIDSCALE 16'h8000
`define SDL_SEG_BITS 4
`define SDL_SEG_COUNT 15
`define SDL_LADDER_BITS 12
`define SDL_SCLK_MAX_HZ 10000000
`define SDL_SYS_HZ 200000000
`define SDL_SCLK_MIN_SYS 4
`define SDL_SYNC_IDLE 5'h1F
`endif

// ---- hw/sdl_loader.sv ----
`timescale 1ns/1ps
`include "sdl_defines.svh"
// Summary of operation
// (RULE1) Input shift register is 16 bits, one bit per falling shift clock edge.
// (RULE2) Reset loads shift and DAC registers with midscale.
// (RULE3) Code is straight binary; zeros most negative, ones top minus LSB.
// (RULE4) Bits accepted only while frame select is low across the word.
// (RULE5) Serial input sampled on each falling shift clock edge.
// (RULE6) Host keeps frame select low until after the sixteenth fall.
// (RULE7) Frame end copies shift register into input register automatically.
// (RULE8) Load strobe low with frame select high loads DAC register.
// (RULE9) Strobe held low while shifting: load on frame select rise.
// (RULE10) Strobe high while shifting: load on strobe falling edge later.
// (RULE11) Top four code bits decode into 15 thermometer segment controls.
// (RULE12) Low twelve bits drive twelve ladder controls directly.
// (RULE13) Clock and data toggling with frame select high change nothing.
// (RULE14) Shift clock up to 10 MHz supported; host keeps below it.
// (RULE15) Frame shorter than sixteen falls is discarded.
// (RULE16) After clear, output stays zero until strobe next goes low; the code also releases it on a frame-end load with strobe held low.
// (RULE17) Power-down beats strobe and clear; registers still writable.
// (RULE18) Excess clocks push shifted-out bits onto serial output.
// (RULE19) Frame with strobe high reads DAC register on serial output.
module sdl_loader
	import sdl_pkg::*;
#(
	parameter int WORD_BITS = `SDL_WORD_BITS
) (
	input wire logic clk_sys_i, // System clock 200 MHz
	input wire logic resetn_i, // Async reset, active low
	input wire logic frame_sel_n_i, // Frame select, active low
	input wire logic shift_clk_i, // Host shift clock
	input wire logic serial_in_i, // Serial data in
	input wire logic load_output_n_i, // Load strobe, active low
	input wire logic output_clear_n_i, // Output clear, active low
	input wire logic power_down_n_i, // Power-down, active low
	output logic serial_out_o, // Serial out level
	output logic serial_out_oe_o, // Open-drain pull-down enable
	output logic output_zero_o, // Analog output forced to zero
	output logic [15:0] dac_code_o, // DAC register
	output sdl_switch_s switch_o // Switch controls
);
	// Sampling needs at least four system clocks per shift clock period
	localparam int SCLK_MIN_SYS = `SDL_SYS_HZ / `SDL_SCLK_MAX_HZ;
	// Datapath slices are fixed at the documented word; other sizes are refused
	if (WORD_BITS != `SDL_WORD_BITS || SCLK_MIN_SYS < `SDL_SCLK_MIN_SYS) begin
		$error("sdl_loader: unsupported configuration");
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [4:0] sync1, sync2, sync3;
	// Idle-high reset levels keep a false edge from following reset
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1 <= `SDL_SYNC_IDLE;
			sync2 <= `SDL_SYNC_IDLE;
			sync3 <= `SDL_SYNC_IDLE;
		end else begin
			sync1 <= {frame_sel_n_i, shift_clk_i, serial_in_i, load_output_n_i,
				output_clear_n_i};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	logic fs_n, sck, sdi, ld_n, clr_n, pd_n1, pd_n;
	assign {fs_n, sck, sdi, ld_n, clr_n} = sync2;
	wire sck_fall = sync3[3] & ~sck; // RULE5 RULE14
	wire fs_fall = sync3[4] & ~fs_n;
	wire fs_rise = ~sync3[4] & fs_n;
	wire ld_fall = sync3[1] & ~ld_n;
	wire clr_fall = sync3[0] & ~clr_n;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pd_n1 <= 1'b1;
			pd_n <= 1'b1;
		end else begin
			pd_n1 <= power_down_n_i;
			pd_n <= pd_n1;
		end
	end

	// ----------------------------------------
	// Frame and shift register
	// ----------------------------------------
	sdl_state_e state;
	logic [15:0] shreg, in_reg;
	logic [4:0] nbits;
	logic [15:0] dac;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= SDL_IDLE;
			shreg <= `SDL_MIDSCALE; // RULE2
			nbits <= '0;
		end else begin
			unique case (state)
				SDL_IDLE: begin
					if (fs_fall) begin // RULE4
						state <= SDL_SHIFT;
						nbits <= '0;
						shreg <= dac; // RULE19
					end
				end
				SDL_SHIFT: begin
					if (fs_n) begin
						state <= SDL_IDLE; // RULE13
					end else if (sck_fall) begin
						shreg <= {shreg[14:0], sdi}; // RULE1 RULE5 RULE18
						// Count saturates: extra clocks of a chained frame still end a word
						if (nbits != 5'(WORD_BITS))
							nbits <= nbits + 5'h01;
					end
				end
				default: state <= SDL_IDLE;
			endcase
		end
	end
	wire word_done = (state == SDL_SHIFT) && fs_n && (nbits == 5'(WORD_BITS));

	// ----------------------------------------
	// Input and DAC registers
	// ----------------------------------------
	logic sync_mode;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_reg <= `SDL_MIDSCALE;
			sync_mode <= 1'b0;
		end else begin
			if (fs_fall)
				sync_mode <= ~ld_n; // RULE9 RULE10
			if (word_done)
				in_reg <= shreg; // RULE7 RULE15 RULE17
		end
	end
	logic [15:0] next_dac;
	logic load_ev;
	always_comb begin
		next_dac = dac;
		load_ev = 1'b0;
		if (word_done && sync_mode) begin
			next_dac = shreg; // RULE9
			load_ev = 1'b1;
		end else if (fs_n && ld_fall && state == SDL_IDLE) begin
			next_dac = in_reg; // RULE8 RULE10
			load_ev = 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			dac <= `SDL_MIDSCALE; // RULE2
		else
			dac <= next_dac; // RULE17
	end

	// ----------------------------------------
	// Output control
	// ----------------------------------------
	logic cleared;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			cleared <= 1'b0;
		else if (!clr_n || clr_fall)
			cleared <= 1'b1; // RULE16
		else if (load_ev)
			cleared <= 1'b0; // RULE16
	end
	sdl_switch_s sw_dec;
	sdl_decoder u_dec (
		.code_i(dac),
		.sw_o(sw_dec)
	);
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			output_zero_o <= 1'b0;
			dac_code_o <= `SDL_MIDSCALE;
			switch_o <= '0;
			serial_out_o <= 1'b1;
			serial_out_oe_o <= 1'b0;
		end else begin
			output_zero_o <= !pd_n || !clr_n || cleared; // RULE17 RULE16
			dac_code_o <= dac;
			switch_o <= sw_dec; // RULE11 RULE12
			// Pull-down released in power-down to save current
			serial_out_o <= 1'b0;
			serial_out_oe_o <= pd_n && !shreg[15]; // RULE18 RULE19
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_word_to_input: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE7
		word_done |=> in_reg == $past(shreg)) else $error("input register missed word");
	a_short_discard: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE15
		(state == SDL_SHIFT && fs_n && nbits != 5'(WORD_BITS)) |=> $stable(in_reg))
		else $error("short frame changed input register");
	a_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE13
		(state == SDL_IDLE && fs_n && !fs_fall) |=> $stable(shreg))
		else $error("shift register moved while idle");
	a_shift_step: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE5
		(state == SDL_SHIFT && !fs_n && sck_fall) |=> shreg == {$past(shreg[14:0]), $past(sdi)})
		else $error("shift step wrong");
	a_async_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE8
		(state == SDL_IDLE && fs_n && ld_fall) |=> dac == $past(in_reg))
		else $error("strobe load missed");
	a_sync_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE9
		(word_done && sync_mode) |=> dac == $past(shreg)) else $error("sync load missed");
	a_no_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE10
		(!load_ev) |=> $stable(dac)) else $error("DAC register changed");
	a_seg_count: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE11
		$countones(sw_dec.segment_switch) == int'(dac[15:12])) else $error("segment decode");
	a_pd_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE17
		!pd_n |=> output_zero_o && !serial_out_oe_o) else $error("power-down not zero");
	a_clear_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RULE16
		(cleared && !load_ev) |=> cleared) else $error("clear released early");
	c_full_word: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) word_done);
	c_sync_load: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		word_done && sync_mode);
	c_async_load: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		load_ev && !word_done);
	c_clear: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) clr_fall);
	c_short_frame: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		fs_rise && state == SDL_SHIFT && nbits != 5'(WORD_BITS));
endmodule

// ---- hw/sdl_pkg.sv ----
package sdl_pkg;
	typedef struct packed {
		logic [14:0] segment_switch;
		logic [11:0] ladder_switch;
	} sdl_switch_s;
	typedef enum logic [1:0] {
		SDL_IDLE = 2'b00,
		SDL_SHIFT = 2'b01
	} sdl_state_e;
endpackage
